// File: rtl/umlc_top.sv
`default_nettype none
module umlc_top (
   input wire logic clock,
   input wire logic reset,
   input wire logic [umlc_pkg::ADDR_W-1:0] addr,
   input wire logic [umlc_pkg::DATA_W-1:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [umlc_pkg::DATA_W-1:0] rdata,
   input wire logic cts_n,
   input wire logic ri_n,
   input wire logic serial_rx_line,
   input wire logic rclk,
   input wire logic tx_shift_bit,
   output logic dtr_n,
   output logic rts_n,
   output logic user_output_a_n,
   output logic user_output_b_n,
   output logic serial_tx_line,
   output logic rx_line_out,
   output logic rclk_tick,
   output logic msr_irq
);
   import umlc_pkg::*;

   // Modem pins pass the synchroniser before any logic reads them
   umlc_sync_if sif ();

   umlc_sync #(.STAGES(SYNC_STAGES)) u_sync (
      .clock(clock),
      .reset(reset),
      .cts_n(cts_n),
      .ri_n(ri_n),
      .serial_rx_line(serial_rx_line),
      .rclk(rclk),
      .sif(sif)
   );

   // Registers and their next values
   logic [DATA_W-1:0] ctrl_q;
   logic [DATA_W-1:0] ctrl_d;
   logic [DATA_W-1:0] ier_q;
   logic [DATA_W-1:0] ier_d;
   logic [DATA_W-1:0] rdata_q;
   logic [DATA_W-1:0] rdata_d;
   logic [DATA_W-1:0] stat_v;
   logic cts_delta_q;
   logic cts_delta_d;
   logic ring_edge_q;
   logic ring_edge_d;
   logic cts_prev_q;
   logic ri_prev_q;
   logic rclk_prev_q;
   logic rclk_tick_q;
   logic [N_PINS-1:0] pins_q;
   logic [N_PINS-1:0] pins_d;
   logic tx_q;
   logic tx_d;

   // Decoded conditions
   logic loop;
   logic loop_d;
   logic cts_act;
   logic ri_lvl;
   logic cts_chg;
   logic ri_rise;
   logic stat_rd;
   logic wr_ctrl;
   logic wr_ien;

   // Register selects
   assign wr_ctrl = wr_en && addr == ADDR_CTRL;
   assign wr_ien = wr_en && addr == ADDR_IEN;
   assign stat_rd = rd_en && addr == ADDR_STAT;

   // Effective modem inputs; loop mode feeds back the RTS and user output A control bits
   assign loop = ctrl_q[CTL_LOOP];
   assign cts_act = loop ? ctrl_q[CTL_RTS] : ~sif.cts_s;
   assign ri_lvl = loop ? ~ctrl_q[CTL_UA] : sif.ri_s;
   assign cts_chg = cts_act != cts_prev_q;
   assign ri_rise = ri_lvl && !ri_prev_q;

   // Set wins over the clear made by a status read
   assign cts_delta_d = cts_chg || (cts_delta_q && !stat_rd);
   assign ring_edge_d = ri_rise || (ring_edge_q && !stat_rd);

   // Unused control and enable bits read back as zero
   assign ctrl_d = wr_ctrl ? (wdata & CTL_MASK) : ctrl_q;
   assign ier_d = wr_ien ? (wdata & IEN_MASK) : ier_q;
   assign loop_d = ctrl_d[CTL_LOOP];

   // Active-low pins; loop mode holds them all inactive
   assign pins_d[PIN_DTR] = loop_d ? PIN_INACTIVE
      : ~ctrl_d[CTL_DTR];
   assign pins_d[PIN_RTS] = loop_d ? PIN_INACTIVE
      : ~ctrl_d[CTL_RTS];
   assign pins_d[PIN_UA] = loop_d ? PIN_INACTIVE
      : ~ctrl_d[CTL_UA];
   assign pins_d[PIN_UB] = loop_d ? PIN_INACTIVE
      : ~ctrl_d[CTL_UB];

   // Serial output idles marking while looped back
   assign tx_d = loop_d ? LINE_MARK : tx_shift_bit;

   // Status view
   always_comb begin
      stat_v = REG_RST;
      stat_v[STA_CTS_CHG] = cts_delta_q;
      stat_v[STA_RING_EDGE] = ring_edge_q;
      stat_v[STA_CTS] = cts_act;
      stat_v[STA_RING] = ~ri_lvl;
   end

   // Read data is zero outside the cycle after a read strobe
   assign rdata_d = !rd_en ? REG_RST :
                    addr == ADDR_CTRL ? ctrl_q :
                    addr == ADDR_STAT ? stat_v :
                    addr == ADDR_IEN ? ier_q : REG_RST;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         ctrl_q <= REG_RST;
         ier_q <= REG_RST;
         rdata_q <= REG_RST;
         cts_delta_q <= 1'b0;
         ring_edge_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         ier_q <= ier_d;
         rdata_q <= rdata_d;
         cts_delta_q <= cts_delta_d;
         ring_edge_q <= ring_edge_d;
      end
   end

   // Previous levels start at the idle levels so reset makes no edge
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         pins_q <= {N_PINS{PIN_INACTIVE}};
         tx_q <= LINE_MARK;
         cts_prev_q <= 1'b0;
         ri_prev_q <= PIN_INACTIVE;
         rclk_prev_q <= 1'b1;
         rclk_tick_q <= 1'b0;
      end else begin
         pins_q <= pins_d;
         tx_q <= tx_d;
         cts_prev_q <= cts_act;
         ri_prev_q <= ri_lvl;
         rclk_prev_q <= sif.rclk_s;
         rclk_tick_q <= sif.rclk_s && !rclk_prev_q;
      end
   end

   assign rdata = rdata_q;
   assign dtr_n = pins_q[PIN_DTR];
   assign rts_n = pins_q[PIN_RTS];
   assign user_output_a_n = pins_q[PIN_UA];
   assign user_output_b_n = pins_q[PIN_UB];
   assign serial_tx_line = tx_q;
   assign rx_line_out = loop ? tx_q : sif.rx_s;
   assign rclk_tick = rclk_tick_q;
   assign msr_irq = ier_q[IEN_MODEM]
      && (cts_delta_q || ring_edge_q);

   // Pin levels after control writes
   AST_OUT_ACTIVE: assert property (@(posedge clock) disable iff (reset)
      wr_ctrl && wdata[CTL_UA] && wdata[CTL_UB] && !wdata[CTL_LOOP]
      |=> !user_output_a_n && !user_output_b_n)
      else $error("user outputs not active after control write");
   AST_OUT_OFF: assert property (@(posedge clock) disable iff (reset)
      wr_ctrl && !wdata[CTL_UA] |=> user_output_a_n)
      else $error("user output a not inactive after clear");
   AST_LOOP_FORCE: assert property (@(posedge clock) disable iff (reset)
      ctrl_q[CTL_LOOP] |-> user_output_a_n && user_output_b_n
      && rts_n && dtr_n)
      else $error("outputs not forced inactive in loop mode");
   AST_RTS_ON: assert property (@(posedge clock) disable iff (reset)
      wr_ctrl && wdata[CTL_RTS] && !wdata[CTL_LOOP] |=> !rts_n)
      else $error("rts not active after set");
   AST_RTS_OFF: assert property (@(posedge clock) disable iff (reset)
      wr_ctrl && !wdata[CTL_RTS] |=> rts_n)
      else $error("rts not inactive after clear");
   AST_DTR: assert property (@(posedge clock) disable iff (reset)
      wr_ctrl |=> dtr_n == ($past(wdata[CTL_LOOP])
      || !$past(wdata[CTL_DTR])))
      else $error("dtr level wrong after control write");

   // Status reads and flags
   AST_RI_READ: assert property (@(posedge clock) disable iff (reset)
      stat_rd |=> rdata[STA_RING] == !$past(ri_lvl))
      else $error("ring bit does not match input");
   AST_RING_TRAILING_EDGE_FLAG_SET: assert property (@(posedge clock) disable iff (reset)
      ri_rise |=> ring_edge_q)
      else $error("trailing edge flag not set");
   AST_RING_FALL: assert property (@(posedge clock) disable iff (reset)
      !ri_rise && !ring_edge_q |=> !ring_edge_q)
      else $error("ring flag set without a rising ring level");
   AST_IRQ: assert property (@(posedge clock) disable iff (reset)
      ri_rise && ier_q[IEN_MODEM] && !wr_ien |=> msr_irq)
      else $error("modem status interrupt missing");
   AST_IRQ_OFF: assert property (@(posedge clock) disable iff (reset)
      !ier_q[IEN_MODEM] |-> !msr_irq)
      else $error("modem status interrupt while disabled");
   AST_CTS_READ: assert property (@(posedge clock) disable iff (reset)
      stat_rd |=> rdata[STA_CTS] == $past(cts_act))
      else $error("cts bit does not match input");
   AST_CLEAR_TO_SEND_DELTA: assert property (@(posedge clock) disable iff (reset)
      cts_chg |=> cts_delta_q ##1 (cts_delta_q || $past(stat_rd)))
      else $error("cts delta not held");
   AST_RD_CLEAR: assert property (@(posedge clock) disable iff (reset)
      stat_rd && !ri_rise && !cts_chg |=> !ring_edge_q && !cts_delta_q)
      else $error("status read did not clear flags");

   // Serial output after reset
   AST_TX_MARK: assert property (@(posedge clock) disable iff (reset)
      $past(reset) |-> serial_tx_line)
      else $error("serial output not marking after reset");

   COV_RING: cover property (@(posedge clock) disable iff (reset)
      ri_rise ##[1:20] stat_rd);
   COV_IRQ: cover property (@(posedge clock) disable iff (reset) $rose(msr_irq));
   COV_LOOP: cover property (@(posedge clock) disable iff (reset)
      $rose(ctrl_q[CTL_LOOP]));
endmodule
`default_nettype wire

// File: pkg/umlc_pkg.sv
// Contract
// - User outputs go low while their control bits are one.
// - Reset and loop mode force both user outputs high.
// - Request-to-send output is active low while its control bit is set.
// - Request-to-send goes high on reset, in loop mode, or bit cleared.
// - Status read returns current ring indicator condition in bit 6.
// - Ring flag sets on ring input low-to-high since last status read.
// - Enabled modem status interrupt rises on ring trailing edge.
// - Reset places serial data output in marking state.
// - Terminal-ready low while bit 0 set; high on reset or loop.
// - Clear-to-send level in bit 4, change flag in bit 0.
`default_nettype none
package umlc_pkg;
   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;
   localparam int SYNC_STAGES = 2;
   localparam int N_SYNC = 4;
   localparam int N_PINS = 4;
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 3'h0;
   localparam logic [ADDR_W-1:0] ADDR_STAT = 3'h1;
   localparam logic [ADDR_W-1:0] ADDR_IEN = 3'h2;
   localparam int CTL_DTR = 0;
   localparam int CTL_RTS = 1;
   localparam int CTL_UA = 2;
   localparam int CTL_UB = 3;
   localparam int CTL_LOOP = 4;
   localparam int STA_CTS_CHG = 0;
   localparam int STA_RING_EDGE = 2;
   localparam int STA_CTS = 4;
   localparam int STA_RING = 6;
   localparam int IEN_MODEM = 0;
   localparam int PIN_DTR = 0;
   localparam int PIN_RTS = 1;
   localparam int PIN_UA = 2;
   localparam int PIN_UB = 3;
   localparam logic [DATA_W-1:0] CTL_MASK = 8'h1F;
   localparam logic [DATA_W-1:0] IEN_MASK = 8'h01;
   localparam logic [DATA_W-1:0] REG_RST = 8'h00;
   localparam logic [N_SYNC-1:0] SYNC_RST = 4'hF;
   localparam logic PIN_INACTIVE = 1'b1;
   localparam logic LINE_MARK = 1'b1;
endpackage
`default_nettype wire

// File: pkg/umlc_sync_if.sv
`default_nettype none
interface umlc_sync_if;
   logic cts_s;
   logic ri_s;
   logic rx_s;
   logic rclk_s;
   modport src (output cts_s, ri_s, rx_s, rclk_s);
   modport dst (input cts_s, ri_s, rx_s, rclk_s);
endinterface
`default_nettype wire

// File: rtl/umlc_sync.sv
`default_nettype none
module umlc_sync #(
   parameter int STAGES = umlc_pkg::SYNC_STAGES
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic cts_n,
   input wire logic ri_n,
   input wire logic serial_rx_line,
   input wire logic rclk,
   umlc_sync_if.src sif
);
   import umlc_pkg::*;
   logic [N_SYNC-1:0] raw;
   logic [N_SYNC-1:0] stage_q [STAGES];

   generate
      if (STAGES < 2) begin : g_bad_stages
         $error("umlc_sync needs at least two stages");
      end
   endgenerate

   assign raw = {rclk, serial_rx_line, ri_n, cts_n};

   // Chain of flip-flops per input
   genvar g;
   generate
      for (g = 0; g < STAGES; g++) begin : g_stage
         always_ff @(posedge clock or posedge reset) begin
            if (reset) begin
               stage_q[g] <= SYNC_RST;
            end else begin
               stage_q[g] <= (g == 0) ? raw : stage_q[(g == 0) ? 0 : g-1];
            end
         end
      end
   endgenerate

   assign sif.cts_s = stage_q[STAGES-1][0];
   assign sif.ri_s = stage_q[STAGES-1][1];
   assign sif.rx_s = stage_q[STAGES-1][2];
   assign sif.rclk_s = stage_q[STAGES-1][3];
endmodule
`default_nettype wire

// File: tb/umlc_modem.sv
`default_nettype none
module umlc_modem (
   input wire logic clock,
   input wire logic ring_on,
   input wire logic cts_on,
   input wire logic rx_bit,
   input wire logic rclk_run,
   output logic ri_n,
   output logic cts_n,
   output logic serial_rx_line,
   output logic rclk = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] div_q = 3'h0;
   assign ri_n = ~ring_on;
   assign cts_n = ~cts_on;
   assign serial_rx_line = rx_bit;
   // Receiver clock of sixteen system clocks, still when stopped
   always @(posedge clock) begin
      div_q <= div_q + 3'h1;
      if (!rclk_run)
         rclk <= 1'b0;
      else if (div_q == 3'h7)
         rclk <= ~rclk;
   end
endmodule
`default_nettype wire

// File: tb/uart_modem_line_control_tb.sv
`default_nettype none
module uart_modem_line_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import umlc_pkg::*;
   typedef struct {logic [7:0] ctl; logic [3:0] pins;} umlc_row_s;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wdata = '0;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic tx_shift_bit = 1'b0;
   logic ring_on = 1'b0, cts_on = 1'b0, rx_bit = 1'b1, rclk_run = 1'b0;
   logic [DATA_W-1:0] rdata, d;
   logic cts_n, ri_n, serial_rx_line, rclk, dtr_n, rts_n, out_a_n, out_b_n;
   logic serial_tx_line, rx_line_out, rclk_tick, msr_irq;
   int mismatches = 0;
   int checks = 0;
   int cycles = 0;
   int ticks;
   umlc_row_s rows[7] = '{'{8'h01, 4'hE}, '{8'h02, 4'hD}, '{8'h04, 4'hB},
      '{8'h08, 4'h7}, '{8'h0F, 4'h0}, '{8'h1F, 4'hF}, '{8'hE0, 4'hF}};
   umlc_modem modem (.clock(clock), .ring_on(ring_on), .cts_on(cts_on),
      .rx_bit(rx_bit), .rclk_run(rclk_run), .ri_n(ri_n), .cts_n(cts_n),
      .serial_rx_line(serial_rx_line), .rclk(rclk));
   umlc_top uut (.clock(clock), .reset(reset), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .cts_n(cts_n),
      .ri_n(ri_n), .serial_rx_line(serial_rx_line), .rclk(rclk),
      .tx_shift_bit(tx_shift_bit), .dtr_n(dtr_n), .rts_n(rts_n),
      .user_output_a_n(out_a_n), .user_output_b_n(out_b_n),
      .serial_tx_line(serial_tx_line), .rx_line_out(rx_line_out),
      .rclk_tick(rclk_tick), .msr_irq(msr_irq));
   always #12.5 clock = ~clock;
   task automatic chk(input string what, input logic [7:0] exp,
         input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic bus_wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge clock);
      addr <= a;
      wdata <= v;
      wr_en <= 1'b1;
      @(posedge clock);
      wr_en <= 1'b0;
      #1;
   endtask
   task automatic bus_rd(input logic [2:0] a, output logic [7:0] v);
      @(posedge clock);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clock);
      rd_en <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic wait_sync();
      repeat (6) @(posedge clock);
      #1;
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         final_report();
      end
   end
   initial begin
      repeat (2) @(posedge clock);
      #1;
      chk("reset tx", 8'h01, {7'h0, serial_tx_line});
      chk("reset pins", 8'h0F, {4'h0, out_b_n, out_a_n, rts_n, dtr_n});
      @(posedge clock);
      reset <= 1'b0;
      $display("test reset ends");
      foreach (rows[i]) begin
         bus_wr(ADDR_CTRL, rows[i].ctl);
         chk("pins", {4'h0, rows[i].pins},
            {4'h0, out_b_n, out_a_n, rts_n, dtr_n});
         bus_rd(ADDR_CTRL, d);
         chk("ctrl", rows[i].ctl & CTL_MASK, d);
      end
      $display("test control table ends");
      bus_wr(ADDR_CTRL, 8'h00);
      bus_wr(ADDR_IEN, 8'h01);
      // Loop rows fed rts and user output a back as cts and ring changes
      bus_rd(ADDR_STAT, d);
      chk("status after loop rows", 8'h05, d);
      chk("irq idle", 8'h00, {7'h0, msr_irq});
      ring_on <= 1'b1;
      wait_sync();
      chk("irq on ring start", 8'h00, {7'h0, msr_irq});
      bus_rd(ADDR_STAT, d);
      chk("status ring", 8'h40, d);
      ring_on <= 1'b0;
      wait_sync();
      chk("irq on ring end", 8'h01, {7'h0, msr_irq});
      bus_rd(ADDR_STAT, d);
      chk("status trailing", 8'h04, d);
      chk("irq after read", 8'h00, {7'h0, msr_irq});
      bus_rd(ADDR_STAT, d);
      chk("status cleared", 8'h00, d);
      cts_on <= 1'b1;
      wait_sync();
      chk("irq on cts", 8'h01, {7'h0, msr_irq});
      bus_rd(ADDR_STAT, d);
      chk("status cts", 8'h11, d);
      bus_rd(3'h7, d);
      chk("unmapped", 8'h00, d);
      $display("test status ends");
      rx_bit <= 1'b0;
      rclk_run <= 1'b1;
      wait_sync();
      chk("rx line", 8'h00, {7'h0, rx_line_out});
      ticks = 0;
      repeat (64) begin
         @(posedge clock);
         #1;
         if (rclk_tick === 1'b1)
            ticks++;
      end
      chk("rclk ticks", 8'h01, {7'h0, ticks inside {[3:5]}});
      chk("tx follows low", 8'h00, {7'h0, serial_tx_line});
      tx_shift_bit <= 1'b1;
      @(posedge clock);
      @(posedge clock);
      #1;
      chk("tx follows high", 8'h01, {7'h0, serial_tx_line});
      tx_shift_bit <= 1'b0;
      bus_wr(ADDR_CTRL, 8'h10);
      wait_sync();
      chk("loop rx", 8'h01, {7'h0, rx_line_out});
      chk("loop tx mark", 8'h01, {7'h0, serial_tx_line});
      $display("test serial ends");
      bus_wr(ADDR_CTRL, 8'h0F);
      chk("pins active", 8'h00, {4'h0, out_b_n, out_a_n, rts_n, dtr_n});
      @(posedge clock);
      reset <= 1'b1;
      @(posedge clock);
      #1;
      chk("mid reset pins", 8'h0F,
         {4'h0, out_b_n, out_a_n, rts_n, dtr_n});
      chk("mid reset tx", 8'h01, {7'h0, serial_tx_line});
      @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      #1;
      chk("pins after reset", 8'h0F,
         {4'h0, out_b_n, out_a_n, rts_n, dtr_n});
      bus_rd(ADDR_CTRL, d);
      chk("ctrl after reset", 8'h00, d);
      $display("test mid-run reset ends");
      final_report();
   end
endmodule
`default_nettype wire
